// [logic/ccp_compare_and_pwm.sv]
// Purpose: compare and pwm section of a capture/compare/pwm unit
// Assumes: timer1 and timer2 live outside; their counts arrive as inputs
// Notes:   capture mode is not part of this block
// Notes on behaviour
// [R1] compare value checked against timer1 count continuously
// [R2] match drives pin high, low or unchanged
// [R3] match sets event flag with pin action
// [R4] zero control write forces compare latch low
// [R5] software makes pin an output for compare
// [R6] timer1 must count synchronously for compare
// [R7] software interrupt mode only raises gated request
// [R8] trigger clears timer1, compare acts as period
// [R9] trigger may also start conversion when enabled
// [R10] trigger clear never sets timer1 overflow flag
// [R11] pwm mode drives up to ten-bit pulse
// [R12] zero control write forces pwm latch low
// [R13] period is period reg plus one, prescaled
// [R14] period match clears timer2, sets pin, loads duty; code drives pin low instead when the loaded duty is zero
// [R15] timer2 postscaler does not shape the period
// [R16] duty is write byte over two control bits
// [R17] high time equals duty times prescaled clock
// [R18] duty writes take effect at period match only
// [R19] duty double buffered, no mid-period glitch
// [R20] pin cleared when duty equals extended timer2
// [R21] duty beyond period never clears, full duty
// [R22] software sets pwm up in documented order
// [R23] mode codes select set, clear, interrupt, flag
// [R24] trigger mode sets the flag too
// [R25] zero mode resets unit, top ones select pwm
`timescale 1ns/1ps
module ccp_compare_and_pwm
	import ccp_pkg::*;
#(
	parameter bit STARTS_ADC = 1'b0 // trigger also starts a conversion
)
(
	input  wire logic              ref_clk,           // core clock, 40 MHz
	input  wire logic              rst,               // async reset, high
	input  wire logic              ctrl_wr,           // unit control write strobe
	input  wire logic [CTRL_W-1:0] ctrl_wdata,        // control write data
	input  wire logic              duty_wr,           // duty write byte strobe
	input  wire logic [BYTE_W-1:0] duty_wdata,        // duty write byte data
	input  wire logic              cmp_hi_wr,         // compare high byte strobe
	input  wire logic [BYTE_W-1:0] cmp_hi_wdata,      // compare high byte data
	input  wire logic              flag_clr,          // clear event flag
	input  wire logic              unit_event_enable, // interrupt enable
	input  wire logic              adc_enable,        // converter enabled
	input  wire logic [CMP_W-1:0]  timer1_count,      // timer1 pair value
	input  wire logic [BYTE_W-1:0] timer2_count,      // timer2 value
	input  wire logic              timer2_inc,        // timer2 increment pulse
	input  wire logic [FINE_W-1:0] timer2_fine,       // quarter phase or prescale
	input  wire logic [BYTE_W-1:0] pwm_period_reg,    // timer2 period value
	output logic                   unit_pin_out,      // unit pin output latch
	output logic                   unit_event_flag,   // sticky event flag
	output logic                   unit_irq,          // gated interrupt request
	output logic                   timer1_clear,      // pulse: clear timer1 pair
	output logic                   adc_start,         // pulse: start conversion
	output logic                   timer2_clear,      // pulse: clear timer2
	output logic [BYTE_W-1:0]      duty_active_reg,   // active duty, read-only
	output logic [CTRL_W-1:0]      unit_control_reg,  // control readback
	output logic [CMP_W-1:0]       compare_value_reg  // compare value readback
);
	logic [CTRL_W-1:0] ctrl_ff;
	logic [BYTE_W-1:0] dwrite_ff;
	logic              eq_prev_ff;
	logic              pin_ff;
	logic              flag_ff;
	logic              irq_ff;
	logic              t1clr_ff;
	logic              adc_ff;
	logic              t2clr_ff;
	logic [DUTY_W-1:0] active;

	logic [CTRL_W-1:0] nxt_ctrl;
	logic [BYTE_W-1:0] nxt_dwrite;
	logic              nxt_pin;
	logic              nxt_flag;

	// decoding of the mode field
	logic [3:0]        mode;
	logic              cmp_mode;
	logic              pwm_mode;
	logic              unit_off;
	logic              zero_wr;
	logic              eq_now;
	logic              cmp_match;
	logic              trig_match;
	logic              period_hit;
	logic [DUTY_W-1:0] duty_buf;
	logic              duty_hit;
	logic              hi_sw_wr;

	function automatic logic mode_is(input logic [3:0] m, input logic [3:0] code);
		mode_is = (m == code);
	endfunction

	assign mode     = ctrl_ff[MODE_MSB:MODE_LSB];
	assign cmp_mode = (mode[3:2] == GRP_CMP);
	assign pwm_mode = (mode[3:2] == GRP_PWM); // R25
	assign unit_off = mode_is(mode, MODE_OFF); // R25
	assign zero_wr  = ctrl_wr && (ctrl_wdata == CTRL_RST);

	// compare path; edge of equality so a stalled timer flags once
	assign eq_now     = (timer1_count == compare_value_reg); // R1
	assign cmp_match  = cmp_mode && eq_now && !eq_prev_ff; // R1 R6
	assign trig_match = cmp_match && mode_is(mode, MODE_TRIG); // R8 R24

	// pwm path; timer2_inc is the prescaled tick, postscaler never seen
	assign period_hit = pwm_mode && timer2_inc && (timer2_count == pwm_period_reg); // R13 R15
	assign duty_buf   = {dwrite_ff, ctrl_ff[DLOW_MSB:DLOW_LSB]}; // R16
	assign duty_hit   = pwm_mode && ({timer2_count, timer2_fine} == active); // R17 R20 R21
	assign hi_sw_wr   = cmp_hi_wr && !pwm_mode; // R18

	// next control and duty write byte
	assign nxt_ctrl   = ctrl_wr ? ctrl_wdata : ctrl_ff;
	assign nxt_dwrite = duty_wr ? duty_wdata : dwrite_ff; // R18

	// pin latch; zero write and unit off beat every other source
	assign nxt_pin = zero_wr                                 ? 1'b0 : // R4 R12
	                 unit_off                                ? 1'b0 : // R25
	                 (cmp_match && mode_is(mode, MODE_SET))  ? 1'b1 : // R2 R23
	                 (cmp_match && mode_is(mode, MODE_CLR))  ? 1'b0 : // R2 R23
	                 period_hit                              ? (duty_buf != DUTY_RST) : // R14
	                 duty_hit                                ? 1'b0 : // R20 R11
	                 pin_ff; // R7

	// set wins over a clear in the same cycle
	assign nxt_flag = cmp_match || (flag_ff && !flag_clr); // R3 R23

	// configuration registers
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_ff   <= CTRL_RST;
			dwrite_ff <= BYTE_RST;
		end
		else
		begin
			ctrl_ff   <= nxt_ctrl;
			dwrite_ff <= nxt_dwrite;
		end
	end

	// output latch and flag
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_ff     <= 1'b0;
			flag_ff    <= 1'b0;
			irq_ff     <= 1'b0;
			eq_prev_ff <= 1'b0;
		end
		else
		begin
			pin_ff     <= nxt_pin;
			flag_ff    <= nxt_flag;
			irq_ff     <= nxt_flag && unit_event_enable; // R7
			eq_prev_ff <= cmp_mode && eq_now;
		end
	end

	// trigger and period pulses; timer1 clear is a plain load, not an overflow
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			t1clr_ff <= 1'b0;
			adc_ff   <= 1'b0;
			t2clr_ff <= 1'b0;
		end
		else
		begin
			t1clr_ff <= trig_match; // R8 R10
			adc_ff   <= trig_match && adc_enable && STARTS_ADC; // R9
			t2clr_ff <= period_hit; // R14
		end
	end

	// active duty, also compare high byte outside pwm mode
	pwm_duty_latch u_duty (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.clear    (unit_off && !pwm_mode),
		.load     (period_hit),
		.load_val (duty_buf),
		.hi_wr    (hi_sw_wr),
		.hi_wdata (cmp_hi_wdata),
		.active   (active)
	); // R18 R19

	assign unit_pin_out      = pin_ff;
	assign unit_event_flag   = flag_ff;
	assign unit_irq          = irq_ff;
	assign timer1_clear      = t1clr_ff;
	assign adc_start         = adc_ff;
	assign timer2_clear      = t2clr_ff;
	assign duty_active_reg   = active[DUTY_W-1:FINE_W];
	assign unit_control_reg  = ctrl_ff;
	assign compare_value_reg = {active[DUTY_W-1:FINE_W], dwrite_ff};

	// checks beside the logic
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	a_match_flag_set: assert property (cmp_match |=> unit_event_flag) // R3
		else $error("match did not set event flag");
	a_match_pin_high: assert property (cmp_match && mode_is(mode, MODE_SET) && !ctrl_wr
		|=> unit_pin_out) // R2
		else $error("set-on-match left pin low");
	a_match_pin_low: assert property (cmp_match && mode_is(mode, MODE_CLR) && !ctrl_wr
		|=> !unit_pin_out) // R2
		else $error("clear-on-match left pin high");
	a_swint_pin_hold: assert property (cmp_match && mode_is(mode, MODE_SWINT) && !ctrl_wr
		|=> $stable(unit_pin_out) && unit_event_flag) // R7
		else $error("software interrupt mode moved pin");
	a_trig_clear_t1: assert property (trig_match |=> timer1_clear ##1 !timer1_clear) // R8
		else $error("trigger did not pulse timer1 clear");
	a_trig_adc_start: assert property (trig_match |=> adc_start == ($past(adc_enable) && STARTS_ADC)) // R9
		else $error("conversion start wrong on trigger");
	a_zero_pin_low: assert property (zero_wr |=> !unit_pin_out [*2]) // R4
		else $error("zero control write did not force pin low");
	a_period_load: assert property (period_hit && !ctrl_wr
		|=> timer2_clear && active == $past(duty_buf)) // R14
		else $error("period match did not reload duty");
	a_period_pin_set: assert property (period_hit && !ctrl_wr
		|=> unit_pin_out == ($past(duty_buf) != DUTY_RST)) // R14
		else $error("pin wrong after period match");
	a_duty_pin_clear: assert property (duty_hit && !period_hit && !ctrl_wr |=> !unit_pin_out) // R20
		else $error("duty match did not clear pin");
	a_duty_held: assert property (pwm_mode && !period_hit && !ctrl_wr |=> $stable(active)) // R18
		else $error("active duty changed mid-period");
	a_irq_gated: assert property (unit_irq |-> unit_event_flag) // R7
		else $error("request without flag");

	// a clear with no new match must drop the flag; set wins otherwise
	a_flag_clear: assert property (flag_clr && !cmp_match |=> !unit_event_flag) // R3
		else $error("flag clear ignored");

	// mode off keeps the pin output latch low
	a_off_pin_low: assert property (unit_off |=> !unit_pin_out) // R25
		else $error("pin high while unit off");

	// no trigger without the special event mode
	a_trig_only_mode: assert property (!trig_match |=> !timer1_clear) // R8
		else $error("timer1 clear without trigger");

	c_swint:      cover property (cmp_match && mode_is(mode, MODE_SWINT));

	c_set_match:  cover property (cmp_match && mode_is(mode, MODE_SET));
	c_trigger:    cover property (trig_match ##1 adc_start);
	c_pwm_period: cover property (period_hit ##[1:300] duty_hit);
	c_zero_write: cover property (pwm_mode && unit_pin_out ##1 zero_wr);
endmodule

// [logic/ccp_pkg.sv]
// Purpose: shared constants of the compare and pwm unit
// Assumes: one core clock, all control inputs synchronous to it
// Notes:   mode codes follow the four-bit mode select field
package ccp_pkg;
	// mode select field encodings
	localparam logic [3:0] MODE_OFF   = 4'h0;
	localparam logic [3:0] MODE_SET   = 4'h8;
	localparam logic [3:0] MODE_CLR   = 4'h9;
	localparam logic [3:0] MODE_SWINT = 4'hA;
	localparam logic [3:0] MODE_TRIG  = 4'hB;
	localparam logic [1:0] GRP_CMP    = 2'h2;
	localparam logic [1:0] GRP_PWM    = 2'h3;

	// field positions inside the unit control register
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 3;
	localparam int DLOW_LSB = 4;
	localparam int DLOW_MSB = 5;

	// widths
	localparam int CMP_W  = 16;
	localparam int CTRL_W = 6;
	localparam int DUTY_W = 10;
	localparam int BYTE_W = 8;
	localparam int FINE_W = 2;

	// values after reset
	localparam logic [5:0]  CTRL_RST = 6'h00;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	localparam logic [9:0]  DUTY_RST = 10'h000;
	localparam logic [15:0] CMP_RST  = 16'h0000;
endpackage

// [logic/pwm_duty_latch.sv]
// Purpose: active duty register plus two-bit internal latch
// Assumes: load is a one-cycle pulse at the period match
// Notes:   upper byte doubles as compare high byte outside pwm mode
`timescale 1ns/1ps
module pwm_duty_latch
	import ccp_pkg::*;
(
	input  wire logic              ref_clk,   // core clock
	input  wire logic              rst,       // async reset, high
	input  wire logic              clear,     // unit turned off
	input  wire logic              load,      // period match copy
	input  wire logic [DUTY_W-1:0] load_val,  // buffered duty value
	input  wire logic              hi_wr,     // software high byte write
	input  wire logic [BYTE_W-1:0] hi_wdata,  // high byte data
	output logic      [DUTY_W-1:0] active     // active duty, registered
);
	logic [DUTY_W-1:0] nxt_active;

	// load has priority so software cannot disturb a running period
	assign nxt_active = clear ? DUTY_RST :
	                    load  ? load_val :
	                    hi_wr ? {hi_wdata, active[FINE_W-1:0]} : active;

	// double buffer storage
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			active <= DUTY_RST;
		else
			active <= nxt_active; // R19
	end
endmodule

// [sim/ccp_compare_and_pwm_tb.sv]
// Purpose: self-checking bench for the compare and pwm unit
// Assumes: period register 7, so one pwm period is 32 core clocks
// Notes:   mid-range high times are compared as a difference to cancel pipeline offsets; zero and full duty are checked absolute
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module ccp_compare_and_pwm_tb;
	import ccp_pkg::*;
	logic ref_clk = 0, rst = 1, ctrl_wr = 0, duty_wr = 0, cmp_hi_wr = 0, flag_clr = 0;
	logic [5:0] ctrl_wdata = '0;
	logic [7:0] duty_wdata = '0, cmp_hi_wdata = '0, timer2_count, pwm_period_reg = 8'h07;
	logic unit_event_enable = 0, adc_enable = 1, timer2_inc, t1_restart = 0;
	logic [15:0] timer1_count;
	logic [1:0] timer2_fine;
	logic unit_pin_out, unit_event_flag, unit_irq, timer1_clear, adc_start, timer2_clear;
	logic [7:0] duty_active_reg;
	logic [5:0] unit_control_reg;
	logic [15:0] compare_value_reg;
	int fails = 0, n_compared = 0, cycles = 0, h1, h2;

	always #12.5 ref_clk = ~ref_clk;

	ccp_compare_and_pwm #(.STARTS_ADC(1'b1)) ccp_compare_and_pwm_inst (.ref_clk(ref_clk),
		.rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .duty_wr(duty_wr),
		.duty_wdata(duty_wdata), .cmp_hi_wr(cmp_hi_wr), .cmp_hi_wdata(cmp_hi_wdata),
		.flag_clr(flag_clr), .unit_event_enable(unit_event_enable), .adc_enable(adc_enable),
		.timer1_count(timer1_count), .timer2_count(timer2_count), .timer2_inc(timer2_inc),
		.timer2_fine(timer2_fine), .pwm_period_reg(pwm_period_reg),
		.unit_pin_out(unit_pin_out), .unit_event_flag(unit_event_flag), .unit_irq(unit_irq),
		.timer1_clear(timer1_clear), .adc_start(adc_start), .timer2_clear(timer2_clear),
		.duty_active_reg(duty_active_reg), .unit_control_reg(unit_control_reg),
		.compare_value_reg(compare_value_reg));

	ccp_timers_model ccp_timers_model_inst (.ref_clk(ref_clk), .rst(rst),
		.timer1_clear(timer1_clear), .t1_restart(t1_restart), .pwm_period_reg(pwm_period_reg),
		.timer1_count(timer1_count), .timer2_count(timer2_count), .timer2_inc(timer2_inc),
		.timer2_fine(timer2_fine));

	// one-cycle strobe: 0 control, 1 duty byte, 2 compare high, 3 flag clear, 4 timer1 restart
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge ref_clk) #2;
		{ctrl_wr, duty_wr, cmp_hi_wr, flag_clr, t1_restart} = 5'h10 >> sel;
		{ctrl_wdata, duty_wdata, cmp_hi_wdata} = {d[5:0], d, d};
		@(posedge ref_clk) #2;
		{ctrl_wr, duty_wr, cmp_hi_wr, flag_clr, t1_restart} = '0;
	endtask

	// arm one compare mode from a fresh timer1 and judge the match outcome
	task automatic cmp_case(input logic [3:0] m, input logic en, input logic ep, input logic et);
		int i;
		logic t1c, ac;
		t1c = 0;
		ac = 0;
		unit_event_enable = en;
		wr(3, 8'h00);
		`CHK(unit_event_flag, 1'b0)
		wr(0, {4'h0, m}); // pin taken as driven output here
		`CHK(unit_control_reg, {2'b00, m})
		wr(4, 8'h00);
		for (i = 0; i < 100 && unit_event_flag !== 1'b1; i++)
		begin
			@(posedge ref_clk) #2;
			t1c |= timer1_clear;
			ac |= adc_start;
		end
		`CHK(unit_event_flag, 1'b1)
		`CHK(unit_pin_out, ep)
		`CHK(unit_irq, en)
		`CHK(t1c, et)
		`CHK(ac, et)
	endtask

	// load a duty, let it take effect, then measure one whole period
	task automatic pwm_case(input logic [9:0] duty, output int hi);
		int i, per;
		for (i = 0; i < 100 && unit_control_reg[3:2] == 2'b11 && timer2_clear !== 1'b1; i++)
			@(posedge ref_clk) #2;
		h2 = duty_active_reg;
		wr(1, duty[9:2]); // period fixed first, duty before mode
		wr(0, {2'b00, duty[1:0], 4'hC});
		`CHK(duty_active_reg, h2[7:0])
		for (i = 0; i < 100 && timer2_clear !== 1'b1; i++)
			@(posedge ref_clk) #2;
		per = 0;
		hi = 0;
		do
		begin
			@(posedge ref_clk) #2;
			per++;
			hi += unit_pin_out;
		end while (timer2_clear !== 1'b1 && per < 100);
		`CHK(per, 32)
		`CHK(duty_active_reg, duty[9:2])
	endtask

	task automatic t_compare;
		wr(1, 8'h20);
		wr(2, 8'h00);
		`CHK(compare_value_reg, 16'h0020)
		cmp_case(MODE_SET, 1'b1, 1'b1, 1'b0);
		cmp_case(MODE_SWINT, 1'b0, 1'b1, 1'b0);
		cmp_case(MODE_CLR, 1'b1, 1'b0, 1'b0);
		cmp_case(MODE_SET, 1'b1, 1'b1, 1'b0);
		wr(0, 8'h00);
		`CHK(unit_pin_out, 1'b0)
		cmp_case(MODE_TRIG, 1'b1, 1'b0, 1'b1);
	endtask

	task automatic t_pwm;
		int h;
		pwm_case(10'h010, h1);
		pwm_case(10'h008, h);
		`CHK(h1 - h, 8)
		pwm_case(10'h000, h);
		`CHK(h, 0)
		pwm_case(10'h3FF, h);
		`CHK(h, 32)
		wr(0, 8'h00);
		`CHK(unit_pin_out, 1'b0)
	endtask

	task automatic end_of_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// the whole run needs about five hundred clocks; the ceiling leaves ample room
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			end_of_test();
		end
	end

	initial
	begin
		repeat (20) @(posedge ref_clk);
		#2 rst = 0;
		t_compare();
		t_pwm();
		end_of_test();
	end
endmodule

// [sim/ccp_timers_model.sv]
// Purpose: behavioural timer1 and timer2 standing beside the unit
// Assumes: timer2 prescale of 1, quarter phase advancing every core clock
// Notes:   timer2 wraps itself on period match; the unit only reports it
`timescale 1ns/1ps
module ccp_timers_model
(
	input  wire logic       ref_clk,        // core clock
	input  wire logic       rst,            // async reset, high
	input  wire logic       timer1_clear,   // trigger clear from the unit
	input  wire logic       t1_restart,     // bench restart of timer1
	input  wire logic [7:0] pwm_period_reg, // timer2 period value
	output logic      [15:0] timer1_count,  // timer1 pair
	output logic      [7:0]  timer2_count,  // timer2 value
	output logic             timer2_inc,    // increment on last quarter
	output logic      [1:0]  timer2_fine    // quarter phase
);
	// the increment lands on the last quarter, so one count spans four clocks
	assign timer2_inc = (timer2_fine == 2'h3);

	// timer1 counts in step with the core clock, never asynchronously
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			timer1_count <= 16'h0000;
		else if (t1_restart || timer1_clear)
			timer1_count <= 16'h0000;
		else
			timer1_count <= timer1_count + 16'h0001;
	end

	// no postscaler sits in this path, so it cannot shape the period
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			{timer2_count, timer2_fine} <= 10'h000;
		else if (timer2_inc && timer2_count == pwm_period_reg)
			{timer2_count, timer2_fine} <= 10'h000;
		else
			{timer2_count, timer2_fine} <= {timer2_count, timer2_fine} + 10'h001;
	end
endmodule
